// File: rtl/tmr_core.sv
// Top of the 8-bit timer/counter with one output compare channel
`timescale 1ns/100ps
module tmr_core
  import tmr_pkg::*;
(
  // Clock and reset
  input  wire logic             MCLK,
  input  wire logic             RST_N,
  // Control fields
  input  wire tmr_ctrl_t        CTRL,
  // Crystal pin input, asynchronous
  input  wire logic             CRYSTAL_IN_PIN,
  // Counter access
  input  wire logic             CNT_WR,
  input  wire logic [7:0]       CNT_WDATA,
  // Compare access
  input  wire logic             CMP_WR,
  input  wire logic [7:0]       CMP_WDATA,
  // Flag register write, one clears
  input  wire logic             FLAG_WR,
  input  wire tmr_flags_t       FLAG_WDATA,
  // Mask register
  input  wire logic             COMPARE_IRQ_ENABLE,
  input  wire logic             OVERFLOW_IRQ_ENABLE,
  // Interrupt taken strobes
  input  wire logic             CMP_IRQ_ACK,
  input  wire logic             OVF_IRQ_ACK,
  // Force compare strobe
  input  wire logic             FORCE_COMPARE_STROBE,
  // Read back
  output logic [7:0]            COUNTER_VALUE,
  output logic [7:0]            COMPARE_VALUE,
  output tmr_flags_t            TIMER_FLAG_REG,
  // Waveform and interrupt outputs
  output logic                  COMPARE_OUTPUT,
  output logic                  CMP_IRQ,
  output logic                  OVF_IRQ
);

  //===========================================================================
  // State
  logic [7:0]  cnt_q;
  logic [7:0]  act_q;
  logic [7:0]  buf_q;
  logic        up_q;
  logic        block_q;
  logic        wave_q;
  tmr_flags_t  flags_q;
  logic        cmp_irq_q;
  logic        ovf_irq_q;
  logic        xs1_q;
  logic        xs2_q;
  logic        xs3_q;
  logic [7:0]  cmp_rd_q;

  //===========================================================================
  // Decoded mode
  logic        pwm_mode;
  logic        at_bottom;
  logic        at_max;
  logic        match;
  logic        top_hit;
  logic        src_pulse;
  logic        tick;
  logic        match_evt;
  logic        ovf_evt;
  logic        load_evt;

  assign pwm_mode  = (CTRL.waveform_mode_field == WGM_PCPWM) ||
                     (CTRL.waveform_mode_field == WGM_FASTPWM);
  assign at_bottom = (cnt_q == CNT_BOTTOM);
  assign at_max    = (cnt_q == CNT_MAX);
  assign match     = (cnt_q == act_q);

  // Top value follows the mode
  always_comb begin
    if (CTRL.waveform_mode_field == WGM_CTC) begin
      top_hit = match;
    end else begin
      top_hit = at_max;
    end
  end

  //===========================================================================
  // Crystal pin synchroniser and edge detect
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      xs1_q <= 1'b0;
      xs2_q <= 1'b0;
      xs3_q <= 1'b0;
    end else begin
      xs1_q <= CRYSTAL_IN_PIN;
      xs2_q <= xs1_q;
      xs3_q <= xs2_q;
    end
  end

  // Source is I/O clock or crystal rising edge
  always_comb begin
    if (CTRL.async_clock_select) begin
      src_pulse = xs2_q && !xs3_q;
    end else begin
      src_pulse = 1'b1;
    end
  end

  tmr_prescaler u_psc (
    .clk                (MCLK),
    .rst_n              (RST_N),
    .src_pulse          (src_pulse),
    .clock_select_field (CTRL.clock_select_field),
    .timer_tick         (tick)
  );

  //===========================================================================
  // Tick events
  assign match_evt = tick && match && !block_q;

  // Overflow point per mode
  always_comb begin
    case (CTRL.waveform_mode_field)
      WGM_PCPWM: ovf_evt = tick && !up_q && at_bottom;
      default:   ovf_evt = tick && at_max;
    endcase
  end

  // Buffer transfer point: top (count at max) for both phase correct and fast
  always_comb begin
    case (CTRL.waveform_mode_field)
      WGM_PCPWM:   load_evt = tick && up_q && at_max;
      WGM_FASTPWM: load_evt = tick && at_max;
      default:     load_evt = 1'b0;
    endcase
  end

  //===========================================================================
  // Counter unit
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cnt_q <= CNT_RST;
    end else if (CNT_WR) begin
      cnt_q <= CNT_WDATA;
    end else if (tick) begin
      case (CTRL.waveform_mode_field)
        WGM_NORMAL: begin
          cnt_q <= cnt_q + 8'h01;
        end
        WGM_CTC: begin
          if (top_hit) begin
            cnt_q <= CNT_BOTTOM;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        WGM_PCPWM: begin
          if (up_q && at_max) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (!up_q && at_bottom) begin
            cnt_q <= cnt_q + 8'h01;
          end else if (up_q) begin
            cnt_q <= cnt_q + 8'h01;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          cnt_q <= cnt_q + 8'h01;
        end
      endcase
    end
  end

  // Count direction, only phase correct ever counts down
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      up_q <= 1'b1;
    end else if (CTRL.waveform_mode_field != WGM_PCPWM) begin
      up_q <= 1'b1;
    end else if (tick && up_q && at_max) begin
      up_q <= 1'b0;
    end else if (tick && !up_q && at_bottom) begin
      up_q <= 1'b1;
    end
  end

  // Match blocking after a counter write, released by the next tick
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      block_q <= 1'b0;
    end else if (CNT_WR) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  //===========================================================================
  // Compare buffer: CPU writes land here in PWM modes
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      buf_q <= CMP_RST;
    end else if (CMP_WR) begin
      buf_q <= CMP_WDATA;
    end
  end

  // Active compare: direct write outside PWM, else loaded at top
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      act_q <= CMP_RST;
    end else if (!pwm_mode) begin
      if (CMP_WR) begin
        act_q <= CMP_WDATA;
      end else begin
        act_q <= act_q;
      end
    end else if (load_evt) begin
      act_q <= buf_q;
    end
  end

  //===========================================================================
  // Waveform generator
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      wave_q <= 1'b0;
    end else if (!pwm_mode) begin
      if (match_evt || FORCE_COMPARE_STROBE) begin
        case (CTRL.compare_output_action)
          COM_TOGGLE: wave_q <= !wave_q;
          COM_CLEAR:  wave_q <= 1'b0;
          COM_SET:    wave_q <= 1'b1;
          default:    wave_q <= wave_q;
        endcase
      end
    end else if (CTRL.waveform_mode_field == WGM_FASTPWM) begin
      if (match_evt) begin
        case (CTRL.compare_output_action)
          COM_CLEAR: wave_q <= 1'b0;
          COM_SET:   wave_q <= 1'b1;
          default:   wave_q <= wave_q;
        endcase
      end else if (tick && at_max) begin
        case (CTRL.compare_output_action)
          COM_CLEAR: wave_q <= 1'b1;
          COM_SET:   wave_q <= 1'b0;
          default:   wave_q <= wave_q;
        endcase
      end
    end else if (match_evt) begin
      case (CTRL.compare_output_action)
        COM_CLEAR: wave_q <= !up_q;
        COM_SET:   wave_q <= up_q;
        default:   wave_q <= wave_q;
      endcase
    end
  end

  //===========================================================================
  // Flags: hardware set beats any clear in the same cycle
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      flags_q.compare_flag <= FLAGS_RST.compare_flag;
    end else if (match_evt) begin
      flags_q.compare_flag <= 1'b1;
    end else if (CMP_IRQ_ACK) begin
      flags_q.compare_flag <= 1'b0;
    end else if (FLAG_WR && FLAG_WDATA.compare_flag) begin
      flags_q.compare_flag <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      flags_q.overflow_flag <= FLAGS_RST.overflow_flag;
    end else if (ovf_evt) begin
      flags_q.overflow_flag <= 1'b1;
    end else if (OVF_IRQ_ACK) begin
      flags_q.overflow_flag <= 1'b0;
    end else if (FLAG_WR && FLAG_WDATA.overflow_flag) begin
      flags_q.overflow_flag <= 1'b0;
    end
  end

  //===========================================================================
  // Masked interrupt requests, registered
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cmp_irq_q <= 1'b0;
      ovf_irq_q <= 1'b0;
    end else begin
      cmp_irq_q <= flags_q.compare_flag && COMPARE_IRQ_ENABLE;
      ovf_irq_q <= flags_q.overflow_flag && OVERFLOW_IRQ_ENABLE;
    end
  end

  // Compare read-back: buffer in PWM modes, active otherwise
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cmp_rd_q <= CMP_RST;
    end else if (pwm_mode) begin
      cmp_rd_q <= buf_q;
    end else begin
      cmp_rd_q <= act_q;
    end
  end

  //===========================================================================
  // Outputs
  assign COUNTER_VALUE  = cnt_q;
  assign COMPARE_VALUE  = cmp_rd_q;
  assign TIMER_FLAG_REG = flags_q;
  assign COMPARE_OUTPUT = wave_q;
  assign CMP_IRQ        = cmp_irq_q;
  assign OVF_IRQ        = ovf_irq_q;

endmodule

// File: rtl/tmr_pkg.sv
// Package with constants and types for the 8-bit timer with compare channel
//=============================================================================
//=============================================================================
package tmr_pkg;

  //===========================================================================
  // Widths and extreme counts
  localparam int          CNT_W       = 8;
  localparam int          PSC_W       = 10;
  localparam logic [7:0]  CNT_BOTTOM  = 8'h00;
  localparam logic [7:0]  CNT_MAX     = 8'hFF;
  localparam logic [7:0]  CNT_RST     = 8'h00;
  localparam logic [7:0]  CMP_RST     = 8'h00;

  //===========================================================================
  // Waveform mode encodings
  localparam logic [1:0]  WGM_NORMAL  = 2'h0;
  localparam logic [1:0]  WGM_PCPWM   = 2'h1;
  localparam logic [1:0]  WGM_CTC     = 2'h2;
  localparam logic [1:0]  WGM_FASTPWM = 2'h3;

  //===========================================================================
  // Compare output actions
  localparam logic [1:0]  COM_NONE    = 2'h0;
  localparam logic [1:0]  COM_TOGGLE  = 2'h1;
  localparam logic [1:0]  COM_CLEAR   = 2'h2;
  localparam logic [1:0]  COM_SET     = 2'h3;

  //===========================================================================
  // Clock select codes and prescaler masks
  localparam logic [2:0]  CS_STOP     = 3'h0;
  localparam logic [9:0]  PSC_DIV1    = 10'h000;
  localparam logic [9:0]  PSC_DIV8    = 10'h007;
  localparam logic [9:0]  PSC_DIV32   = 10'h01F;
  localparam logic [9:0]  PSC_DIV64   = 10'h03F;
  localparam logic [9:0]  PSC_DIV128  = 10'h07F;
  localparam logic [9:0]  PSC_DIV256  = 10'h0FF;
  localparam logic [9:0]  PSC_DIV1024 = 10'h3FF;

  //===========================================================================
  // Control bundle from the CPU side
  typedef struct packed {
    logic       async_clock_select;
    logic [2:0] clock_select_field;
    logic [1:0] waveform_mode_field;
    logic [1:0] compare_output_action;
  } tmr_ctrl_t;

  // Flag register layout
  typedef struct packed {
    logic compare_flag;
    logic overflow_flag;
  } tmr_flags_t;

  localparam tmr_flags_t FLAGS_RST = '{compare_flag: 1'b0,
                                       overflow_flag: 1'b0};

endpackage

// File: rtl/tmr_prescaler.sv
// Ten-bit prescaler producing the timer tick from a source pulse
`timescale 1ns/100ps
module tmr_prescaler
  import tmr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Source pulse and divide selection
  input  wire logic       src_pulse,
  input  wire logic [2:0] clock_select_field,
  // Timer tick
  output logic            timer_tick
);

  //===========================================================================
  // Mask of low prescaler bits that must all be one for a tick
  function automatic logic [9:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h1:    div_mask = PSC_DIV1;
      3'h2:    div_mask = PSC_DIV8;
      3'h3:    div_mask = PSC_DIV32;
      3'h4:    div_mask = PSC_DIV64;
      3'h5:    div_mask = PSC_DIV128;
      3'h6:    div_mask = PSC_DIV256;
      3'h7:    div_mask = PSC_DIV1024;
      default: div_mask = PSC_DIV1;
    endcase
  endfunction

  logic [PSC_W-1:0] psc_q;
  logic [PSC_W-1:0] mask;

  assign mask = div_mask(clock_select_field);

  // Free-running divider, advanced by each source pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      psc_q <= '0;
    end else if (src_pulse) begin
      psc_q <= psc_q + 10'h001;
    end
  end

  // Tick when the selected low bits roll over; none when stopped
  assign timer_tick = src_pulse && (clock_select_field != CS_STOP)
                      && ((psc_q & mask) == mask);

endmodule

// File: tb/tmr_core_sva.sv
// Checker of port relations for the timer core
`timescale 1ns/100ps
module tmr_core_chk
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic       MCLK,
  input wire logic       RST_N,
  // Controls and strobes
  input wire tmr_ctrl_t  CTRL,
  input wire logic       CNT_WR,
  input wire logic [7:0] CNT_WDATA,
  input wire logic       CMP_WR,
  input wire logic       FLAG_WR,
  input wire tmr_flags_t FLAG_WDATA,
  input wire logic       COMPARE_IRQ_ENABLE,
  input wire logic       CMP_IRQ_ACK,
  // Observed outputs
  input wire logic [7:0] COUNTER_VALUE,
  input wire logic [7:0] COMPARE_VALUE,
  input wire tmr_flags_t TIMER_FLAG_REG,
  input wire logic       CMP_IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  //===========================================================================
  // Counter behaviour
  chk_write_lands: assert property (
    CNT_WR |=> COUNTER_VALUE == $past(CNT_WDATA))
    else $error("counter write lost");
  chk_stop_holds: assert property (
    CTRL.clock_select_field == CS_STOP && !CNT_WR
    && $past(CTRL.clock_select_field) == CS_STOP |=> $stable(COUNTER_VALUE))
    else $error("stopped counter moved");
  chk_count_step: assert property (
    $past(RST_N) && !$past(CNT_WR) && COUNTER_VALUE != $past(COUNTER_VALUE)
    && $past(CTRL.waveform_mode_field) == WGM_NORMAL
    |-> COUNTER_VALUE == $past(COUNTER_VALUE) + 8'h01)
    else $error("normal count not plus one");
  chk_ovf_at_wrap: assert property (
    $past(RST_N) && !$past(CNT_WR) && $past(COUNTER_VALUE) == CNT_MAX
    && COUNTER_VALUE == CNT_BOTTOM
    && $past(CTRL.waveform_mode_field) == WGM_NORMAL
    |-> TIMER_FLAG_REG.overflow_flag)
    else $error("no overflow flag at wrap");

  //===========================================================================
  // Compare flag and request
  chk_irq_gated: assert property (
    $past(RST_N) |-> CMP_IRQ ==
    ($past(TIMER_FLAG_REG.compare_flag) && $past(COMPARE_IRQ_ENABLE)))
    else $error("compare request not flag and enable");
  chk_flag_clear: assert property (
    FLAG_WR && FLAG_WDATA.compare_flag && CTRL.clock_select_field == CS_STOP
    && $past(CTRL.clock_select_field) == CS_STOP
    |=> !TIMER_FLAG_REG.compare_flag)
    else $error("one written did not clear flag");
  chk_flag_keeps: assert property (
    TIMER_FLAG_REG.compare_flag && !CMP_IRQ_ACK
    && !(FLAG_WR && FLAG_WDATA.compare_flag) |=> TIMER_FLAG_REG.compare_flag)
    else $error("compare flag lost");
  chk_flag_cause: assert property (
    $past(RST_N) && $rose(TIMER_FLAG_REG.compare_flag)
    && $past(CTRL.waveform_mode_field) == WGM_NORMAL
    && !$past(CMP_WR, 2) && !$past(CMP_WR, 3)
    |-> $past(COUNTER_VALUE) == $past(COMPARE_VALUE))
    else $error("compare flag without match");
  chk_write_blocks: assert property (
    CNT_WR && CNT_WDATA == COMPARE_VALUE && COUNTER_VALUE != COMPARE_VALUE
    && !TIMER_FLAG_REG.compare_flag
    && CTRL.waveform_mode_field == WGM_NORMAL
    |=> !TIMER_FLAG_REG.compare_flag [*2])
    else $error("match after counter write");
endmodule

bind tmr_core tmr_core_chk u_tmr_core_chk (
  .MCLK(MCLK), .RST_N(RST_N), .CTRL(CTRL), .CNT_WR(CNT_WR),
  .CNT_WDATA(CNT_WDATA), .CMP_WR(CMP_WR), .FLAG_WR(FLAG_WR),
  .FLAG_WDATA(FLAG_WDATA), .COMPARE_IRQ_ENABLE(COMPARE_IRQ_ENABLE),
  .CMP_IRQ_ACK(CMP_IRQ_ACK), .COUNTER_VALUE(COUNTER_VALUE),
  .COMPARE_VALUE(COMPARE_VALUE), .TIMER_FLAG_REG(TIMER_FLAG_REG),
  .CMP_IRQ(CMP_IRQ));

// File: tb/tmr_cpu_model.sv
// CPU side model that takes the compare interrupt
`timescale 1ns/100ps
module tmr_cpu_model (
  // Clock
  input wire logic       clk,
  // Request and handling controls
  input wire logic       irq,
  input wire logic       take_en,
  input wire logic [3:0] delay,
  // Interrupt taken strobe
  output logic           ack
);
  // Enters the handler after a chosen delay, one cycle strobe
  initial begin
    ack = 1'b0;
    forever begin
      @(negedge clk);
      if (irq && take_en) begin
        repeat (delay) @(negedge clk);
        ack = 1'b1;
        @(negedge clk);
        ack = 1'b0;
        repeat (3) @(negedge clk); // Let the request fall first
      end
    end
  end
endmodule

// File: tb/tmr_core_bench.sv
// Self-checking bench of the timer core
`timescale 1ns/100ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end
module tmr_core_bench
  import tmr_pkg::*;
;
  logic       mclk, rst_n, xtal, cnt_wr, cmp_wr, flag_wr, fstrobe;
  logic       cmp_en, ovf_en, cmp_ack, ovf_ack, take_en, cout;
  logic       cmp_irq, ovf_irq, o;
  logic [3:0] ack_dly;
  logic [7:0] cnt_wdata, cmp_wdata, cnt_val, cmp_val, mx;
  tmr_ctrl_t  ctrl;
  tmr_flags_t flag_wdata, flags;
  int         errors, tests_run;

  //===========================================================================
  // Design and CPU model
  tmr_core u_tmr_core (.MCLK(mclk), .RST_N(rst_n), .CTRL(ctrl),
    .CRYSTAL_IN_PIN(xtal), .CNT_WR(cnt_wr), .CNT_WDATA(cnt_wdata),
    .CMP_WR(cmp_wr), .CMP_WDATA(cmp_wdata), .FLAG_WR(flag_wr),
    .FLAG_WDATA(flag_wdata), .COMPARE_IRQ_ENABLE(cmp_en),
    .OVERFLOW_IRQ_ENABLE(ovf_en), .CMP_IRQ_ACK(cmp_ack),
    .OVF_IRQ_ACK(ovf_ack), .FORCE_COMPARE_STROBE(fstrobe),
    .COUNTER_VALUE(cnt_val), .COMPARE_VALUE(cmp_val),
    .TIMER_FLAG_REG(flags), .COMPARE_OUTPUT(cout), .CMP_IRQ(cmp_irq),
    .OVF_IRQ(ovf_irq));
  tmr_cpu_model u_tmr_cpu_model (.clk(mclk), .irq(cmp_irq),
    .take_en(take_en), .delay(ack_dly), .ack(cmp_ack));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  //===========================================================================
  // Shared helpers
  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Strobe 0 counter, 1 compare, 2 flags, 3 force
  task strobe(input int k, input logic [7:0] v);
    @(negedge mclk);
    {cnt_wr, cmp_wr, flag_wr, fstrobe} = 4'h8 >> k;
    cnt_wdata = v;
    cmp_wdata = v;
    flag_wdata = v[1:0];
    @(negedge mclk);
    {cnt_wr, cmp_wr, flag_wr, fstrobe} = 4'h0;
  endtask
  task wait_cnt(input logic [7:0] v);
    for (int i = 0; i < 600 && cnt_val !== v; i++) @(negedge mclk);
    `CHK("count reached", v, cnt_val)
  endtask
  task run(input logic [1:0] wgm, input logic [2:0] cs);
    ctrl.waveform_mode_field = wgm;
    ctrl.clock_select_field = cs;
  endtask

  //===========================================================================
  // Scenarios
  task t_stop;
    run(WGM_NORMAL, CS_STOP);
    strobe(0, 8'h5A);
    cyc(20);
    `CHK("held count", 8'h5A, cnt_val)
    $display("stop test done");
  endtask
  task t_overflow;
    ovf_en = 1'b1;
    strobe(0, 8'hFD);
    run(WGM_NORMAL, 3'h1);
    wait_cnt(8'h00);
    `CHK("overflow flag", 1'b1, flags.overflow_flag)
    cyc(1);
    `CHK("overflow irq", 1'b1, ovf_irq)
    run(WGM_NORMAL, CS_STOP);
    ovf_en = 1'b0;
    cyc(2);
    `CHK("masked overflow irq", 1'b0, ovf_irq)
    ovf_ack = 1'b1;
    cyc(1);
    ovf_ack = 1'b0;
    `CHK("overflow flag taken", 1'b0, flags.overflow_flag)
    $display("overflow test done");
  endtask
  task t_compare;
    strobe(2, 8'h03);
    strobe(1, 8'h40);
    strobe(0, 8'h30);
    run(WGM_NORMAL, 3'h1);
    wait_cnt(8'h48);
    run(WGM_NORMAL, CS_STOP);
    `CHK("compare flag", 1'b1, flags.compare_flag)
    `CHK("masked compare irq", 1'b0, cmp_irq)
    strobe(2, 8'h01);
    `CHK("flag after zero", 1'b1, flags.compare_flag)
    cmp_en = 1'b1;
    cyc(2);
    `CHK("compare irq", 1'b1, cmp_irq)
    strobe(2, 8'h02);
    `CHK("flag after one", 1'b0, flags.compare_flag)
    take_en = 1'b1;
    strobe(0, 8'h3E);
    run(WGM_NORMAL, 3'h1);
    wait_cnt(8'h50);
    run(WGM_NORMAL, CS_STOP);
    cyc(10);
    `CHK("flag after taken", 1'b0, flags.compare_flag)
    `CHK("irq after taken", 1'b0, cmp_irq)
    {take_en, cmp_en} = 2'h0;
    $display("compare test done");
  endtask
  task t_ctc;
    run(WGM_CTC, CS_STOP);
    strobe(1, 8'h05);
    strobe(0, 8'h00);
    mx = 8'h00;
    run(WGM_CTC, 3'h1);
    repeat (40) begin
      @(negedge mclk);
      if (cnt_val > mx) mx = cnt_val;
    end
    run(WGM_CTC, CS_STOP);
    `CHK("ctc top", 8'h05, mx)
    $display("ctc test done");
  endtask
  task t_block;
    run(WGM_NORMAL, CS_STOP);
    strobe(1, 8'h20);
    strobe(2, 8'h03);
    strobe(0, 8'h20);
    run(WGM_NORMAL, 3'h1);
    cyc(4);
    run(WGM_NORMAL, CS_STOP);
    `CHK("blocked match", 1'b0, flags.compare_flag)
    $display("block test done");
  endtask
  task t_force;
    ctrl.compare_output_action = COM_TOGGLE;
    o = cout;
    strobe(3, 8'h00);
    `CHK("forced output", ~o, cout)
    `CHK("force sets no flag", 1'b0, flags.compare_flag)
    run(WGM_FASTPWM, CS_STOP);
    o = cout;
    strobe(3, 8'h00);
    `CHK("pwm force ignored", o, cout)
    ctrl.compare_output_action = COM_NONE;
    $display("force test done");
  endtask
  task t_buffer;
    strobe(1, 8'h33);
    cyc(1);
    `CHK("buffer read", 8'h33, cmp_val)
    strobe(0, 8'h10);
    run(WGM_FASTPWM, 3'h1);
    wait_cnt(8'h30);
    `CHK("old compare kept", 1'b1, flags.compare_flag)
    wait_cnt(8'h10);
    strobe(2, 8'h03);
    wait_cnt(8'h30);
    run(WGM_FASTPWM, CS_STOP);
    `CHK("loaded at top", 1'b0, flags.compare_flag)
    $display("buffer test done");
  endtask
  task t_clocks;
    run(WGM_NORMAL, CS_STOP);
    strobe(0, 8'h00);
    run(WGM_NORMAL, 3'h2);
    cyc(80);
    run(WGM_NORMAL, CS_STOP);
    `CHK("div8 count", 1'b1, cnt_val >= 8'h09 && cnt_val <= 8'h0B)
    strobe(0, 8'h00);
    ctrl.async_clock_select = 1'b1;
    run(WGM_NORMAL, 3'h1);
    cyc(6);
    repeat (4) begin
      xtal = 1'b1;
      cyc(3);
      xtal = 1'b0;
      cyc(4);
    end
    cyc(5);
    `CHK("crystal count", 8'h04, cnt_val)
    run(WGM_NORMAL, CS_STOP);
    ctrl.async_clock_select = 1'b0;
    $display("clock test done");
  endtask
  task t_pcpwm;
    run(WGM_NORMAL, CS_STOP);
    strobe(1, 8'h80);
    ctrl.compare_output_action = COM_SET;
    strobe(3, 8'h00);
    `CHK("forced set", 1'b1, cout)
    strobe(2, 8'h03);
    ctrl.compare_output_action = COM_CLEAR;
    run(WGM_PCPWM, CS_STOP);
    strobe(0, 8'h7E);
    run(WGM_PCPWM, 3'h1);
    wait_cnt(8'h90);
    `CHK("up match clears", 1'b0, cout)
    wait_cnt(8'hFF);
    cyc(1);
    `CHK("turn at top", 8'hFE, cnt_val)
    `CHK("no overflow at top", 1'b0, flags.overflow_flag)
    wait_cnt(8'h70);
    `CHK("down match sets", 1'b1, cout)
    wait_cnt(8'h00);
    cyc(1);
    run(WGM_PCPWM, CS_STOP);
    `CHK("turn at bottom", 8'h01, cnt_val)
    `CHK("overflow at bottom", 1'b1, flags.overflow_flag)
    ctrl.compare_output_action = COM_NONE;
    $display("phase correct test done");
  endtask

  //===========================================================================
  // Ending
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_n, xtal, cnt_wr, cmp_wr, flag_wr, fstrobe} = 6'h00;
    {cmp_en, ovf_en, ovf_ack, take_en} = 4'h0;
    {cnt_wdata, cmp_wdata} = 16'h0000;
    ack_dly = 4'h3;
    ctrl = '0;
    flag_wdata = '0;
    errors = 0;
    tests_run = 0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    t_stop;
    t_overflow;
    t_compare;
    t_ctc;
    t_block;
    t_force;
    t_buffer;
    t_clocks;
    t_pcpwm;
    wrap_up;
  end

  // Watchdog
  initial begin
    repeat (8000) @(posedge mclk);
    errors++;
    wrap_up;
  end
endmodule
